// ==== src/ctas_alert_status.sv ====
// Alert status registers with APB slave and interrupt
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "ctas_defs.svh"

module ctas_alert_status #(
   parameter int DATA_W = 16
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`CTAS_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Acquisition results, same clock domain
   input wire logic acqDone,
   input wire logic [`CTAS_NUM_CELLS-1:0][DATA_W-1:0] cellVoltage,
   input wire logic [DATA_W-1:0] aux0Voltage,
   input wire logic [DATA_W-1:0] aux1Voltage,
   input wire logic [`CTAS_NUM_CELLS-1:0][DATA_W-1:0] diagResult,
   // Thresholds from the threshold registers
   input wire logic [DATA_W-1:0] overVoltageThresholdSetting,
   input wire logic [DATA_W-1:0] underVoltageThresholdSetting,
   input wire logic [DATA_W-1:0] auxUpperThreshold,
   input wire logic [DATA_W-1:0] auxLowerThreshold,
   // Interrupt
   output logic irq
);

   // ****************************************
   // State and comparator
   // ****************************************
   ctas_pkg::ctas_state_t s;
   ctas_pkg::ctas_state_t next_s;
   logic [15:0] overWord;
   logic [15:0] underWord;
   logic [15:0] balanceWord;
   logic [31:0] readData;
   logic addrHit;
   logic accessStart;
   logic writeDone;
   logic [2:0] events;

   // Comparisons run continuously; only acqDone samples them
   ctas_compare #(
      .DATA_W(DATA_W)
   ) u_compare (
      .cellVoltage(cellVoltage),
      .aux0Voltage(aux0Voltage),
      .aux1Voltage(aux1Voltage),
      .diagResult(diagResult),
      .overVoltageThresholdSetting(overVoltageThresholdSetting),
      .underVoltageThresholdSetting(underVoltageThresholdSetting),
      .auxUpperThreshold(auxUpperThreshold),
      .auxLowerThreshold(auxLowerThreshold),
      .cellOverVoltageEnable(s.ovEnable),
      .cellUnderVoltageEnable(s.uvEnable),
      .balanceDiagThresholdSelect(s.diagSelect),
      .overWord(overWord),
      .underWord(underWord),
      .balanceWord(balanceWord)
   );

   // ****************************************
   // Bus decode
   // ****************************************

   // First access cycle starts the answer, second one completes
   assign accessStart = psel & penable & ~s.pready;
   assign writeDone = psel & penable & pwrite & s.pready;

   // Read mux; unmapped addresses answer with an error
   always_comb
   begin
      readData = 32'h0000_0000;
      addrHit = 1'b1;
      case (paddr)
         `CTAS_ADDR_OVER: readData = {16'h0000, s.overStatus};
         `CTAS_ADDR_UNDER: readData = {16'h0000, s.underStatus};
         `CTAS_ADDR_BALANCE: readData = {16'h0000, s.balanceStatus};
         `CTAS_ADDR_OV_ENABLE: readData = {20'h00000, s.ovEnable};
         `CTAS_ADDR_UV_ENABLE: readData = {20'h00000, s.uvEnable};
         `CTAS_ADDR_DIAG_SELECT: readData = {29'h0000_0000, s.diagSelect};
         `CTAS_ADDR_INT_STATUS: readData = {29'h0000_0000, s.intStatus};
         `CTAS_ADDR_INT_MASK: readData = {29'h0000_0000, s.intMask};
         default: addrHit = 1'b0;
      endcase
   end

   // New alert rising at an acquisition, one bit per register
   always_comb
   begin
      events = 3'h0;
      events[`CTAS_INT_OVER] = acqDone & (|(overWord & ~s.overStatus));
      events[`CTAS_INT_UNDER] = acqDone & (|(underWord & ~s.underStatus));
      events[`CTAS_INT_BALANCE] = acqDone & (|(balanceWord & ~s.balanceStatus));
   end

   // ****************************************
   // Next state
   // ****************************************
   always_comb
   begin
      next_s = s;
      next_s.pready = 1'b0;
      next_s.pslverr = 1'b0;
      // Answer one cycle into the access phase
      if (accessStart)
      begin
         next_s.pready = 1'b1;
         next_s.pslverr = ~addrHit;
         next_s.prdata = pwrite ? 32'h0000_0000 : readData;
      end
      if (writeDone)
      begin
         case (paddr)
            `CTAS_ADDR_OV_ENABLE: next_s.ovEnable = pwdata[`CTAS_NUM_CELLS-1:0];
            `CTAS_ADDR_UV_ENABLE: next_s.uvEnable = pwdata[`CTAS_NUM_CELLS-1:0];
            `CTAS_ADDR_DIAG_SELECT: next_s.diagSelect = pwdata[2:0];
            `CTAS_ADDR_INT_STATUS: next_s.intStatus = s.intStatus & ~pwdata[2:0];
            `CTAS_ADDR_INT_MASK: next_s.intMask = pwdata[2:0];
            default: next_s.intMask = s.intMask;
         endcase
      end
      // whole snapshot taken on one edge
      if (acqDone)
      begin
         next_s.overStatus = overWord;
         next_s.underStatus = underWord;
         next_s.balanceStatus = balanceWord;
      end
      // Set beats a same-cycle write-one clear
      next_s.intStatus = next_s.intStatus | events;
      next_s.irq = |(next_s.intStatus & next_s.intMask);
   end

   // State register
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         s.overStatus <= `CTAS_ALERT_RESET;
         s.underStatus <= `CTAS_ALERT_RESET;
         s.balanceStatus <= `CTAS_ALERT_RESET;
         s.ovEnable <= `CTAS_ENABLE_RESET;
         s.uvEnable <= `CTAS_ENABLE_RESET;
         s.diagSelect <= `CTAS_DIAG_RESET;
         s.intStatus <= `CTAS_INT_RESET;
         s.intMask <= `CTAS_INT_RESET;
         s.prdata <= 32'h0000_0000;
         s.pready <= 1'b0;
         s.pslverr <= 1'b0;
         s.irq <= 1'b0;
      end
      else
      begin
         s <= next_s;
      end
   end

   // Outputs straight from flops
   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign irq = s.irq;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_b);

   // Access phase that has not yet been answered
   sequence accessWait_s;
      psel & penable & ~pready;
   endsequence

   // Completed write to one of the alert registers
   sequence alertWrite_s;
      psel & penable & pwrite & pready & ~acqDone &
         (paddr == `CTAS_ADDR_OVER || paddr == `CTAS_ADDR_UNDER || paddr == `CTAS_ADDR_BALANCE);
   endsequence

   // Bus answers after exactly one wait cycle, then drops
   apb_answer_timing_a: assert property (accessWait_s |=> pready ##1 !pready)
      else $error("APB answer not one cycle after access start");

   reserved_bits_zero_a: assert property (s.overStatus[`CTAS_RES_MSB:`CTAS_RES_LSB] == 2'h0 &&
      s.underStatus[`CTAS_RES_MSB:`CTAS_RES_LSB] == 2'h0 &&
      s.balanceStatus[`CTAS_RES_MSB:`CTAS_BAL_RES_LSB] == 4'h0)
      else $error("Reserved alert bit reads one");

   aux_cold_alert_a: assert property (acqDone |=>
      s.overStatus[`CTAS_AUX1_BIT] == $past(aux1Voltage > auxUpperThreshold) &&
      s.overStatus[`CTAS_AUX0_BIT] == $past(aux0Voltage > auxUpperThreshold))
      else $error("Cold aux alert mismatch");

   aux_hot_alert_a: assert property (acqDone |=>
      s.underStatus[`CTAS_AUX1_BIT] == $past(aux1Voltage < auxLowerThreshold) &&
      s.underStatus[`CTAS_AUX0_BIT] == $past(aux0Voltage < auxLowerThreshold))
      else $error("Hot aux alert mismatch");

   cell_over_gate_a: assert property (acqDone |=>
      (s.overStatus[`CTAS_NUM_CELLS-1:0] & ~$past(s.ovEnable)) == 12'h000)
      else $error("Over-voltage alert on disabled cell");

   cell_under_gate_a: assert property (acqDone |=>
      (s.underStatus[`CTAS_NUM_CELLS-1:0] & ~$past(s.uvEnable)) == 12'h000)
      else $error("Under-voltage alert on disabled cell");

   balance_capture_a: assert property (acqDone |=> s.balanceStatus == $past(balanceWord))
      else $error("Balance alert not captured");

   balance_hold_a: assert property (!acqDone |=> $stable(s.balanceStatus))
      else $error("Balance alert changed without acquisition");

   alert_readonly_a: assert property (alertWrite_s |=> $stable(s.overStatus) && $stable(s.underStatus) &&
      $stable(s.balanceStatus))
      else $error("Alert register changed by a write");

   alerts_together_a: assert property ($changed(s.overStatus) || $changed(s.underStatus) ||
      $changed(s.balanceStatus) |-> $past(acqDone))
      else $error("Alert bits changed outside an acquisition");

   // Interrupt follows masked status, event set wins
   irq_level_a: assert property (irq == |(s.intStatus & s.intMask))
      else $error("Interrupt does not match masked status");

   event_sticky_a: assert property (|events |=> (s.intStatus & $past(events)) == $past(events))
      else $error("Alert event lost");

   // Completed clear of interrupt status; set wins, so no acquisition alongside
   sequence intClear_s;
      psel & penable & pwrite & pready & ~acqDone & (paddr == `CTAS_ADDR_INT_STATUS);
   endsequence

   // Completed write to the over-voltage enable register
   sequence enableWrite_s;
      psel & penable & pwrite & pready & (paddr == `CTAS_ADDR_OV_ENABLE);
   endsequence

   // Waiting access phase to an address with no register
   sequence badAccess_s;
      psel & penable & ~pready & ~addrHit;
   endsequence

   // Write-one clear takes out the written bits
   int_clear_a: assert property (intClear_s |=> (s.intStatus & $past(pwdata[2:0])) == 3'h0)
      else $error("Interrupt status bit not cleared by write");

   // Enable write lands at the completing edge
   enable_write_a: assert property (enableWrite_s |=> s.ovEnable == $past(pwdata[`CTAS_NUM_CELLS-1:0]))
      else $error("Over-voltage enable write lost");

   // Unmapped address answers with an error
   unmapped_error_a: assert property (badAccess_s |=> pready && pslverr)
      else $error("Unmapped access answered without error");

   // Mapped address never answers with an error
   mapped_no_error_a: assert property (accessWait_s ##0 addrHit |=> !pslverr)
      else $error("Mapped access answered with error");

   // Writes return zero read data
   write_data_zero_a: assert property (accessWait_s ##0 pwrite |=> prdata == 32'h0000_0000)
      else $error("Write answer carries read data");

   // ****************************************
   // Per-cell capture checks
   // ****************************************
   // The gate checks above only catch spurious bits;
   // these also catch a missed alert on an enabled cell
   for (genvar c = 0; c < `CTAS_NUM_CELLS; c++)
   begin : g_cell_chk
      cell_over_set_a: assert property (acqDone |=>
         s.overStatus[c] == $past(s.ovEnable[c] && (cellVoltage[c] > overVoltageThresholdSetting)))
         else $error("Over-voltage alert bit wrong after acquisition");

      cell_under_set_a: assert property (acqDone |=>
         s.underStatus[c] == $past(s.uvEnable[c] && (cellVoltage[c] < underVoltageThresholdSetting)))
         else $error("Under-voltage alert bit wrong after acquisition");
   end

endmodule // ctas_alert_status

// ==== src/ctas_defs.svh ====
// Constants for the cell threshold alert status block
`ifndef CTAS_DEFS_SVH
`define CTAS_DEFS_SVH

// ****************************************
// Geometry
// ****************************************
`define CTAS_NUM_CELLS 12
`define CTAS_AUX1_BIT 13
`define CTAS_AUX0_BIT 12
`define CTAS_RES_MSB 15
`define CTAS_RES_LSB 14
`define CTAS_BAL_RES_LSB 12
`define CTAS_ADDR_W 12

// ****************************************
// Register indices and byte addresses
// ****************************************
`define CTAS_IDX_OVER 10'h005
`define CTAS_IDX_UNDER 10'h007
`define CTAS_IDX_BALANCE 10'h008
`define CTAS_ADDR_OVER {`CTAS_IDX_OVER, 2'h0}
`define CTAS_ADDR_UNDER {`CTAS_IDX_UNDER, 2'h0}
`define CTAS_ADDR_BALANCE {`CTAS_IDX_BALANCE, 2'h0}
`define CTAS_ADDR_OV_ENABLE 12'h040
`define CTAS_ADDR_UV_ENABLE 12'h044
`define CTAS_ADDR_DIAG_SELECT 12'h048
`define CTAS_ADDR_INT_STATUS 12'h04C
`define CTAS_ADDR_INT_MASK 12'h050

// ****************************************
// Reset values
// ****************************************
`define CTAS_ALERT_RESET 16'h0000
`define CTAS_ENABLE_RESET 12'h000
`define CTAS_DIAG_RESET 3'h0
`define CTAS_INT_RESET 3'h0

// ****************************************
// Interrupt status bits
// ****************************************
`define CTAS_INT_OVER 0
`define CTAS_INT_UNDER 1
`define CTAS_INT_BALANCE 2

// ****************************************
// Balance diagnostic thresholds, one per select code
// ****************************************
`define CTAS_DIAG_THR_0 16'h0100
`define CTAS_DIAG_THR_1 16'h0200
`define CTAS_DIAG_THR_2 16'h0400
`define CTAS_DIAG_THR_3 16'h0800
`define CTAS_DIAG_THR_4 16'h1000
`define CTAS_DIAG_THR_5 16'h2000
`define CTAS_DIAG_THR_6 16'h4000
`define CTAS_DIAG_THR_7 16'h8000

`endif

// ==== src/ctas_pkg.sv ====
// Types shared by the cell threshold alert status block
`include "ctas_defs.svh"

package ctas_pkg;

   // All registered state of the top module
   typedef struct packed {
      logic [15:0] overStatus;
      logic [15:0] underStatus;
      logic [15:0] balanceStatus;
      logic [`CTAS_NUM_CELLS-1:0] ovEnable;
      logic [`CTAS_NUM_CELLS-1:0] uvEnable;
      logic [2:0] diagSelect;
      logic [2:0] intStatus;
      logic [2:0] intMask;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic irq;
   } ctas_state_t;

endpackage

// ==== src/ctas_compare.sv ====
// Threshold comparators producing the next alert words
`timescale 1ns/1ps
`include "ctas_defs.svh"

module ctas_compare #(
   parameter int DATA_W = 16
) (
   // Measurement results
   input wire logic [`CTAS_NUM_CELLS-1:0][DATA_W-1:0] cellVoltage,
   input wire logic [DATA_W-1:0] aux0Voltage,
   input wire logic [DATA_W-1:0] aux1Voltage,
   input wire logic [`CTAS_NUM_CELLS-1:0][DATA_W-1:0] diagResult,
   // Thresholds and enables
   input wire logic [DATA_W-1:0] overVoltageThresholdSetting,
   input wire logic [DATA_W-1:0] underVoltageThresholdSetting,
   input wire logic [DATA_W-1:0] auxUpperThreshold,
   input wire logic [DATA_W-1:0] auxLowerThreshold,
   input wire logic [`CTAS_NUM_CELLS-1:0] cellOverVoltageEnable,
   input wire logic [`CTAS_NUM_CELLS-1:0] cellUnderVoltageEnable,
   input wire logic [2:0] balanceDiagThresholdSelect,
   // Next alert words
   output logic [15:0] overWord,
   output logic [15:0] underWord,
   output logic [15:0] balanceWord
);

   logic [`CTAS_NUM_CELLS-1:0] ovHit;
   logic [`CTAS_NUM_CELLS-1:0] uvHit;
   logic [`CTAS_NUM_CELLS-1:0] balHit;
   logic [DATA_W-1:0] diagThreshold;

   always_comb
   begin
      case (balanceDiagThresholdSelect)
         3'h0: diagThreshold = DATA_W'(`CTAS_DIAG_THR_0);
         3'h1: diagThreshold = DATA_W'(`CTAS_DIAG_THR_1);
         3'h2: diagThreshold = DATA_W'(`CTAS_DIAG_THR_2);
         3'h3: diagThreshold = DATA_W'(`CTAS_DIAG_THR_3);
         3'h4: diagThreshold = DATA_W'(`CTAS_DIAG_THR_4);
         3'h5: diagThreshold = DATA_W'(`CTAS_DIAG_THR_5);
         3'h6: diagThreshold = DATA_W'(`CTAS_DIAG_THR_6);
         default: diagThreshold = DATA_W'(`CTAS_DIAG_THR_7);
      endcase
   end

   // Per-cell comparisons; cell n lands on bit n
   for (genvar i = 0; i < `CTAS_NUM_CELLS; i++)
   begin : g_cell
      assign ovHit[i] = cellOverVoltageEnable[i] & (cellVoltage[i] > overVoltageThresholdSetting);
      assign uvHit[i] = cellUnderVoltageEnable[i] & (cellVoltage[i] < underVoltageThresholdSetting);
      assign balHit[i] = diagResult[i] > diagThreshold;
   end

   // cold aux bits; upper bits zero
   assign overWord = {2'h0, aux1Voltage > auxUpperThreshold, aux0Voltage > auxUpperThreshold, ovHit};
   // hot aux bits; upper bits zero
   assign underWord = {2'h0, aux1Voltage < auxLowerThreshold, aux0Voltage < auxLowerThreshold, uvHit};
   assign balanceWord = {4'h0, balHit};

endmodule // ctas_compare

// ==== bench/ctas_alert_status_tb.sv ====
// Self-checking bench for the cell threshold alert status block
`timescale 1ns/1ps
`include "ctas_defs.svh"
`define CHK(nm, ex, gt) begin samplesChecked++; if ((gt) !== (ex)) begin nErrors++; \
   $display("mismatch %s expected %h seen %h", nm, ex, gt); end end

module ctas_alert_status_tb;
   // ****************************************
   // Signals
   // ****************************************
   logic sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, acqDone, irq;
   logic [`CTAS_ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rd, wv;
   logic [`CTAS_NUM_CELLS-1:0][15:0] cellVoltage, diagResult, sCell, sDiag;
   logic [15:0] aux0Voltage, aux1Voltage, ovThr, uvThr, upThr, loThr, sAux0, sAux1;
   logic [15:0] eo, eu, eb, po, pu, pb;
   logic [11:0] ovEn, uvEn;
   logic [2:0] sel, mask, expInt;
   logic [11:0] regAddr [8];
   logic err;
   int nErrors, samplesChecked;

   ctas_alert_status dut (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .acqDone(acqDone), .cellVoltage(cellVoltage), .aux0Voltage(aux0Voltage),
      .aux1Voltage(aux1Voltage), .diagResult(diagResult), .overVoltageThresholdSetting(ovThr),
      .underVoltageThresholdSetting(uvThr), .auxUpperThreshold(upThr), .auxLowerThreshold(loThr),
      .irq(irq));

   // Free-running 40 MHz clock
   initial
   begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   // ****************************************
   // Tasks and functions
   // ****************************************
   // One APB transfer; waits for pready under a bound, never a fixed count
   // Ready and data are looked at mid-cycle, where they are settled for the next rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int t;
      logic rdy;
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      penable <= 1'b0;
      @(posedge sys_clk);
      penable <= 1'b1;
      t = 0;
      do
      begin
         @(negedge sys_clk);
         t++;
         rdy = (pready === 1'b1);
         rd = prdata;
         err = pslverr;
         @(posedge sys_clk);
      end
      while (!rdy && t < 50);
      if (!rdy)
      begin
         nErrors++;
         final_report();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Values near a threshold so the strict compare boundary is hit often
   function automatic logic [15:0] near(input logic [15:0] t);
      case ($urandom_range(3))
         0: return t - 16'h0001;
         1: return t;
         2: return t + 16'h0001;
         default: return 16'($urandom);
      endcase
   endfunction

   // Reference words and interrupt events for the shadow inputs
   task automatic model();
      eo = '0;
      eu = '0;
      eb = '0;
      for (int n = 0; n < 12; n++)
      begin
         eo[n] = ovEn[n] && (sCell[n] > ovThr);
         eu[n] = uvEn[n] && (sCell[n] < uvThr);
         eb[n] = sDiag[n] > (16'h0100 << sel);
      end
      eo[13] = sAux1 > upThr;
      eo[12] = sAux0 > upThr;
      eu[13] = sAux1 < loThr;
      eu[12] = sAux0 < loThr;
      expInt |= {|(eb & ~pb), |(eu & ~pu), |(eo & ~po)};
      po = eo;
      pu = eu;
      pb = eb;
   endtask

   // k back-to-back acquisitions with fresh data each cycle
   task automatic acq(input int k);
      repeat (k)
      begin
         @(posedge sys_clk);
         for (int n = 0; n < 12; n++)
         begin
            sCell[n] = near($urandom_range(1) ? ovThr : uvThr);
            sDiag[n] = near(16'h0100 << sel);
         end
         sAux0 = near($urandom_range(1) ? upThr : loThr);
         sAux1 = near($urandom_range(1) ? upThr : loThr);
         model();
         acqDone <= 1'b1;
         cellVoltage <= sCell;
         diagResult <= sDiag;
         aux0Voltage <= sAux0;
         aux1Voltage <= sAux1;
      end
      @(posedge sys_clk);
      acqDone <= 1'b0;
      #1;
   endtask

   task automatic final_report();
      if (nErrors == 0 && samplesChecked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Watchdog, far beyond the expected few thousand cycles
   initial
   begin
      #(25 * 20000);
      nErrors++;
      final_report();
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata, acqDone} = '0;
      {cellVoltage, diagResult, aux0Voltage, aux1Voltage} = '0;
      {po, pu, pb, expInt, ovEn, uvEn, sel, mask} = '0;
      {ovThr, uvThr, upThr, loThr} = {16'h8000, 16'h4000, 16'h9000, 16'h3000};
      nErrors = 0;
      samplesChecked = 0;
      rst_b = 1'b0;
      void'($urandom(32'h0D2EE485));
      repeat (2) @(posedge sys_clk);
      rst_b <= 1'b1;
      // Reset values of every register, alert words first
      regAddr = '{`CTAS_ADDR_OVER, `CTAS_ADDR_UNDER, `CTAS_ADDR_BALANCE, `CTAS_ADDR_OV_ENABLE,
         `CTAS_ADDR_UV_ENABLE, `CTAS_ADDR_DIAG_SELECT, `CTAS_ADDR_INT_STATUS, `CTAS_ADDR_INT_MASK};
      foreach (regAddr[i])
      begin
         apb(1'b0, regAddr[i], 32'h0);
         `CHK("reset value", 32'h0, rd)
      end
      // Unmapped address answers with an error and zero data
      apb(1'b0, 12'h100, 32'h0);
      `CHK("unmapped err", 1'b1, err)
      `CHK("unmapped data", 32'h0, rd)
      for (int it = 0; it < 48; it++)
      begin
         // Corner enables first, then random; every select code in turn
         wv = (it == 0) ? 32'hFFFFFFFF : (it == 1) ? 32'h0 : $urandom;
         ovEn = wv[11:0];
         apb(1'b1, 12'h040, wv);
         wv = (it == 0) ? 32'hFFFFFFFF : (it == 1) ? 32'h0 : $urandom;
         uvEn = wv[11:0];
         apb(1'b1, 12'h044, wv);
         sel = 3'(it);
         apb(1'b1, 12'h048, {29'($urandom), sel});
         mask = 3'($urandom);
         apb(1'b1, 12'h050, {29'h0, mask});
         ovThr = 16'($urandom_range(16'hFE00, 16'h0100));
         uvThr = 16'($urandom_range(16'hFE00, 16'h0100));
         upThr = 16'($urandom_range(16'hFE00, 16'h0100));
         loThr = 16'($urandom_range(16'hFE00, 16'h0100));
         acq((it % 6 == 5) ? 2 : 1);
         `CHK("irq", |(expInt & mask), irq)
         // Software writes to the over-voltage alert word must not stick
         apb(1'b1, `CTAS_ADDR_OVER, $urandom);
         `CHK("alert write err", 1'b0, err)
         apb(1'b0, `CTAS_ADDR_OVER, 32'h0);
         `CHK("over status", {16'h0, eo}, rd)
         apb(1'b0, `CTAS_ADDR_UNDER, 32'h0);
         `CHK("under status", {16'h0, eu}, rd)
         apb(1'b0, `CTAS_ADDR_BALANCE, 32'h0);
         `CHK("balance status", {16'h0, eb}, rd)
         apb(1'b0, 12'h048, 32'h0);
         `CHK("diag select", {29'h0, sel}, rd)
         apb(1'b0, 12'h040, 32'h0);
         `CHK("ov enable", {20'h0, ovEn}, rd)
         apb(1'b0, 12'h04C, 32'h0);
         `CHK("int status", {29'h0, expInt}, rd)
         wv = $urandom;
         apb(1'b1, 12'h04C, wv);
         expInt &= ~wv[2:0];
         #1;
         `CHK("irq after clear", |(expInt & mask), irq)
      end
      final_report();
   end
endmodule // ctas_alert_status_tb
